// file: core/lamc_regs.svh
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 8-bit register space, core clock of 100 MHz
// Notes:   include by bare name; definitions only
`ifndef LAMC_REGS_SVH
`define LAMC_REGS_SVH

`define LAMC_OFS_PROX_GAIN     8'h0b
`define LAMC_OFS_PROX_MISC     8'h0c
`define LAMC_OFS_AMB_IR_SEL    8'h0e
`define LAMC_OFS_AUX_SEL       8'h0f
`define LAMC_OFS_VIS_RECOVERY  8'h10

`define LAMC_GAIN_LSB          0
`define LAMC_GAIN_W            3
`define LAMC_RANGE_BIT         5
`define LAMC_MODE_BIT          2
`define LAMC_REC_LSB           4
`define LAMC_REC_W             3

`define LAMC_RST_PROX_GAIN     8'h00
`define LAMC_RST_PROX_MISC     8'h04
`define LAMC_RST_AMB_IR_SEL    8'h00
`define LAMC_RST_AUX_SEL       8'h65
`define LAMC_RST_VIS_RECOVERY  8'h70

`define LAMC_MUX_SMALL_IR      8'h00
`define LAMC_MUX_LARGE_IR      8'h03
`define LAMC_MUX_TEMPERATURE   8'h65
`define LAMC_MUX_SUPPLY        8'h75

`define LAMC_ADC_CLK_NS        50
`define LAMC_CORE_CLK_NS       10
`define LAMC_ADC_BASE_CYC      ((`LAMC_ADC_CLK_NS + `LAMC_CORE_CLK_NS - 1) / `LAMC_CORE_CLK_NS)
`define LAMC_INTEG_ADC_CLKS    256

`endif

// file: core/lamc_pkg.sv
// Purpose: shared types of the measurement configuration block
// Assumes: constants live in lamc_regs.svh
// Notes:   enums carry no explicit codes
package lamc_pkg;

  typedef logic [7:0] lamc_byte_t;

  typedef enum logic [1:0] {
    MEAS_PROX,
    MEAS_VIS,
    MEAS_AMB_IR,
    MEAS_AUX
  } lamc_meas_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_RECOVER,
    ST_INTEG,
    ST_DONE
  } lamc_state_t;

endpackage

// file: core/lamc_timer.sv
// Purpose: reloading down counter used as divider and phase timer
// Assumes: tick_i is a one-cycle enable on core_clk_i
// Notes:   value v gives one pulse every v+1 ticks; v of zero passes ticks
`timescale 1ns/100ps
module lamc_timer #(
  parameter int W = 8
) (
  input  wire logic         core_clk_i,
  input  wire logic         srst_i,
  input  wire logic         load_i,
  input  wire logic [W-1:0] value_i,
  input  wire logic         tick_i,
  output logic              pulse_o
);

  logic [W-1:0] cnt;
  logic [W-1:0] reload;
  logic [W-1:0] next_cnt;
  logic         at_zero;

  assign at_zero  = (cnt == '0);
  assign next_cnt = at_zero ? reload : cnt - {{(W-1){1'b0}}, 1'b1};
  // load not masked here: a load fed by this pulse would close a loop
  assign pulse_o  = tick_i & at_zero;

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      cnt    <= '0;
      reload <= '0;
    end
    else if (load_i)
    begin
      cnt    <= value_i;
      reload <= value_i;
    end
    else if (tick_i)
    begin
      cnt <= next_cnt;
    end
  end

endmodule

// file: core/lamc_top.sv
// Purpose: measurement configuration settings and the sequencer timing
//          they steer (gain divider, recovery wait, LED, mux, range)
// Assumes: plain register port, read data one cycle after the strobe
// Notes:   settings are captured at the start of each measurement
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/100ps
`include "lamc_regs.svh"

// Behaviour
// - prox LED pulse and integration both stretched by two to the gain.
// - any prox gain exponent is used as written, never clamped.
// - prox gain exponent zero runs the ADC clock undivided.
// - range bit 5 clear is normal range, set is high range.
// - mode bit 2 low is raw ADC, high is normal proximity.
// - raw ADC mode keeps all LED drives off during prox measurements.
// - ambient IR selector 0x00 small diode, 0x03 large diode.
// - aux selector 0x65 temperature, 0x75 supply, both against ground.
// - visible recovery waits 1, 7, 15 up to 511 ADC clocks, gain scaled.
// - prox misc setting resets to 0x04.
// - aux selector resets to the temperature code.
// - visible recovery setting resets to 0x70.
// - early silicon also applies visible recovery to ambient IR.
module lamc_top
  import lamc_pkg::*;
#(
  parameter int INTEG_ADC_CLKS = `LAMC_INTEG_ADC_CLKS
) (
  input  wire logic       core_clk_i,
  input  wire logic       srst_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  output logic      [7:0] reg_rdata_o,
  input  wire logic       meas_start_i,
  input  wire lamc_meas_t meas_kind_i,
  input  wire logic [7:0] prox_input_sel_i,
  input  wire logic [7:0] vis_input_sel_i,
  input  wire logic [2:0] visible_gain_exponent_i,
  input  wire logic       vis_high_range_i,
  input  wire logic       early_rev_i,
  output logic            meas_busy_o,
  output logic            meas_done_o,
  output logic            recovering_o,
  output logic            integrating_o,
  output logic            adc_clk_en_o,
  output logic      [7:0] adc_input_sel_o,
  output logic            adc_high_range_o,
  output logic            led_drive_en_o
);

  localparam int DIV_W   = 8;
  localparam int PHASE_W = 10;
  localparam lamc_byte_t RST_GAIN = `LAMC_RST_PROX_GAIN;
  localparam lamc_byte_t RST_MISC = `LAMC_RST_PROX_MISC;
  localparam lamc_byte_t RST_REC  = `LAMC_RST_VIS_RECOVERY;

  // settings, reserved bits are never stored
  logic [2:0]  prox_gain_exponent;
  logic        prox_high_range;
  logic        prox_measure_mode;
  lamc_byte_t  ambient_ir_input_sel;
  lamc_byte_t  aux_input_sel;
  logic [2:0]  visible_recovery_code;

  // strap synchroniser, three stages
  logic        rev_sync1;
  logic        rev_sync2;
  logic        rev_sync3;
  logic        early_rev;

  // sequencer
  lamc_state_t state;
  lamc_state_t next_state;
  lamc_meas_t  kind;
  logic [2:0]  meas_gain;
  logic        meas_led;
  logic        meas_wait;

  // timing chain
  logic              base_tick;
  logic              adc_tick;
  logic              phase_pulse;
  logic              start_take;
  logic              phase_load;
  logic [PHASE_W-1:0] phase_val;
  logic [DIV_W-1:0]  gain_div_val;
  logic [PHASE_W-1:0] rec_val;
  logic [PHASE_W-1:0] integ_val;
  logic [2:0]        start_gain;
  logic              start_wait;
  logic              start_led;
  lamc_byte_t        start_sel;
  logic              start_range;

  // register port decode
  logic       hit_gain;
  logic       hit_misc;
  logic       hit_ir;
  logic       hit_aux;
  logic       hit_rec;
  lamc_byte_t rd_mux;

  assign hit_gain = (reg_addr_i == `LAMC_OFS_PROX_GAIN);
  assign hit_misc = (reg_addr_i == `LAMC_OFS_PROX_MISC);
  assign hit_ir   = (reg_addr_i == `LAMC_OFS_AMB_IR_SEL);
  assign hit_aux  = (reg_addr_i == `LAMC_OFS_AUX_SEL);
  assign hit_rec  = (reg_addr_i == `LAMC_OFS_VIS_RECOVERY);

  // unmapped addresses read zero, writes to them are dropped
  always_comb
  begin
    rd_mux = 8'h00;
    if (hit_gain)
    begin
      rd_mux[`LAMC_GAIN_LSB +: `LAMC_GAIN_W] = prox_gain_exponent;
    end
    else if (hit_misc)
    begin
      rd_mux[`LAMC_RANGE_BIT] = prox_high_range;
      rd_mux[`LAMC_MODE_BIT]  = prox_measure_mode;
    end
    else if (hit_ir)
    begin
      rd_mux = ambient_ir_input_sel;
    end
    else if (hit_aux)
    begin
      rd_mux = aux_input_sel;
    end
    else if (hit_rec)
    begin
      rd_mux[`LAMC_REC_LSB +: `LAMC_REC_W] = visible_recovery_code;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      reg_rdata_o <= 8'h00;
    end
    else if (reg_rd_i)
    begin
      reg_rdata_o <= rd_mux;
    end
  end

  // no range check: an overdriven gain is the host's responsibility
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      prox_gain_exponent <= RST_GAIN[`LAMC_GAIN_LSB +: `LAMC_GAIN_W];
      prox_high_range    <= RST_MISC[`LAMC_RANGE_BIT];
      prox_measure_mode  <= RST_MISC[`LAMC_MODE_BIT];
      ambient_ir_input_sel  <= `LAMC_RST_AMB_IR_SEL;
      aux_input_sel         <= `LAMC_RST_AUX_SEL;
      visible_recovery_code <= RST_REC[`LAMC_REC_LSB +: `LAMC_REC_W];
    end
    else if (reg_wr_i)
    begin
      if (hit_gain)
      begin
        prox_gain_exponent <= reg_wdata_i[2:0];
      end
      if (hit_misc)
      begin
        prox_high_range   <= reg_wdata_i[`LAMC_RANGE_BIT];
        prox_measure_mode <= reg_wdata_i[`LAMC_MODE_BIT];
      end
      if (hit_ir)
      begin
        ambient_ir_input_sel <= reg_wdata_i;
      end
      if (hit_aux)
      begin
        aux_input_sel <= reg_wdata_i;
      end
      if (hit_rec)
      begin
        visible_recovery_code <= reg_wdata_i[6:4];
      end
    end
  end

  // strap: a change counts once stages two and three agree
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      rev_sync1 <= 1'b0;
      rev_sync2 <= 1'b0;
      rev_sync3 <= 1'b0;
      early_rev <= 1'b0;
    end
    else
    begin
      rev_sync1 <= early_rev_i;
      rev_sync2 <= rev_sync1;
      rev_sync3 <= rev_sync2;
      if (rev_sync2 == rev_sync3)
      begin
        early_rev <= rev_sync3;
      end
    end
  end

  // per-kind settings chosen at the start of a measurement
  assign start_take = (state == ST_IDLE) & meas_start_i;

  assign start_gain =
    (meas_kind_i == MEAS_PROX) ? prox_gain_exponent :
    (meas_kind_i == MEAS_VIS)  ? visible_gain_exponent_i :
    (meas_kind_i == MEAS_AMB_IR && early_rev) ? visible_gain_exponent_i :
    3'h0;

  assign start_wait =
    (meas_kind_i == MEAS_VIS) |
    ((meas_kind_i == MEAS_AMB_IR) & early_rev);

  // raw mode never lights the LEDs
  assign start_led = (meas_kind_i == MEAS_PROX) & prox_measure_mode;

  assign start_sel =
    (meas_kind_i == MEAS_PROX)   ? prox_input_sel_i :
    (meas_kind_i == MEAS_VIS)    ? vis_input_sel_i :
    (meas_kind_i == MEAS_AMB_IR) ? ambient_ir_input_sel :
    aux_input_sel;

  assign start_range =
    (meas_kind_i == MEAS_PROX) ? prox_high_range :
    (meas_kind_i == MEAS_VIS)  ? vis_high_range_i :
    1'b0;

  // divide ratio 2^gain; gain zero gives value zero, an undivided clock
  assign gain_div_val = DIV_W'((1 << start_gain) - 1);

  // code zero waits one clock, code n above zero 2^(n+2)-1 clocks
  assign rec_val   = (visible_recovery_code == 3'h0) ? '0 :
    PHASE_W'((4 << visible_recovery_code) - 2);
  assign integ_val = PHASE_W'(INTEG_ADC_CLKS - 1);

  // a start without recovery goes straight to integration
  assign phase_load = start_take | ((state == ST_RECOVER) & phase_pulse);
  assign phase_val  = ((state == ST_RECOVER) | ~start_wait) ? integ_val :
    rec_val;

  lamc_timer #(
    .W (DIV_W)
  ) u_base_div (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .load_i     (start_take),
    .value_i    (DIV_W'(`LAMC_ADC_BASE_CYC - 1)),
    .tick_i     (1'b1),
    .pulse_o    (base_tick)
  );

  // stretches LED pulse and integration alike, both count adc_tick
  lamc_timer #(
    .W (DIV_W)
  ) u_gain_div (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .load_i     (start_take),
    .value_i    (gain_div_val),
    .tick_i     (base_tick),
    .pulse_o    (adc_tick)
  );

  lamc_timer #(
    .W (PHASE_W)
  ) u_phase (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .load_i     (phase_load),
    .value_i    (phase_val),
    .tick_i     (adc_tick & meas_busy_o),
    .pulse_o    (phase_pulse)
  );

  always_comb
  begin
    next_state = state;
    case (state)
      ST_IDLE:
      begin
        if (meas_start_i)
        begin
          next_state = start_wait ? ST_RECOVER : ST_INTEG;
        end
      end
      ST_RECOVER:
      begin
        if (phase_pulse)
        begin
          next_state = ST_INTEG;
        end
      end
      ST_INTEG:
      begin
        if (phase_pulse)
        begin
          next_state = ST_DONE;
        end
      end
      ST_DONE:
      begin
        next_state = ST_IDLE;
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      state <= ST_IDLE;
    end
    else
    begin
      state <= next_state;
    end
  end

  // captured copies keep one measurement consistent under host writes
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      kind             <= MEAS_PROX;
      meas_gain        <= 3'h0;
      meas_led         <= 1'b0;
      meas_wait        <= 1'b0;
      adc_input_sel_o  <= 8'h00;
      adc_high_range_o <= 1'b0;
    end
    else if (start_take)
    begin
      kind             <= meas_kind_i;
      meas_gain        <= start_gain;
      meas_led         <= start_led;
      meas_wait        <= start_wait;
      adc_input_sel_o  <= start_sel;
      adc_high_range_o <= start_range;
    end
  end

  // status decoded straight from the state register
  assign meas_busy_o   = (state == ST_RECOVER) | (state == ST_INTEG);
  assign recovering_o  = (state == ST_RECOVER);
  assign integrating_o = (state == ST_INTEG);
  assign meas_done_o   = (state == ST_DONE);
  assign adc_clk_en_o  = adc_tick & meas_busy_o;
  assign led_drive_en_o = (state == ST_INTEG) & meas_led;

endmodule

// file: verification/lamc_top_properties.sv
// Purpose: port assertions for lamc_top
// Assumes: settings shadowed from bus writes, captured at start
// Notes:   bound to lamc_top below the module
`timescale 1ns/100ps
`include "lamc_regs.svh"
module lamc_props
  import lamc_pkg::*;
(
  input wire logic       core_clk_i,
  input wire logic       srst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       reg_wr_i,
  input wire logic       meas_start_i,
  input wire lamc_meas_t meas_kind_i,
  input wire logic       meas_busy_o,
  input wire logic       meas_done_o,
  input wire logic       recovering_o,
  input wire logic       integrating_o,
  input wire logic       adc_clk_en_o,
  input wire logic [7:0] adc_input_sel_o,
  input wire logic       adc_high_range_o,
  input wire logic       led_drive_en_o
);
  logic [7:0] g_q, m_q, ir_q, aux_q;
  lamc_meas_t k_q;
  logic       lm_q;
  wire acc  = meas_start_i && !meas_busy_o && !meas_done_o;
  wire accp = acc && meas_kind_i == MEAS_PROX;
  wire wg   = reg_wr_i && reg_addr_i == `LAMC_OFS_PROX_GAIN;
  wire wm   = reg_wr_i && reg_addr_i == `LAMC_OFS_PROX_MISC;
  wire wi   = reg_wr_i && reg_addr_i == `LAMC_OFS_AMB_IR_SEL;
  wire wx   = reg_wr_i && reg_addr_i == `LAMC_OFS_AUX_SEL;

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      g_q   <= `LAMC_RST_PROX_GAIN;
      m_q   <= `LAMC_RST_PROX_MISC;
      ir_q  <= `LAMC_RST_AMB_IR_SEL;
      aux_q <= `LAMC_RST_AUX_SEL;
      k_q   <= MEAS_VIS;
      lm_q  <= 1'b0;
    end
    else
    begin
      if (wg) g_q <= reg_wdata_i;
      if (wm) m_q <= reg_wdata_i;
      if (wi) ir_q <= reg_wdata_i;
      if (wx) aux_q <= reg_wdata_i;
      // settings of the running measurement, not the live ones
      if (acc) k_q <= meas_kind_i;
      if (acc) lm_q <= m_q[`LAMC_MODE_BIT];
    end
  end

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (srst_i);

  AST_UNDIV: assert property (accp && g_q[2:0] == 3'h0 |->
    ##1 (!adc_clk_en_o) [*4] ##1 adc_clk_en_o) else $error("tick not at 5");
  AST_STRETCH: assert property (accp && g_q[2:0] == 3'h1 |->
    ##1 (!adc_clk_en_o) [*8] ##2 adc_clk_en_o) else $error("tick not at 10");
  AST_LED_RAW: assert property (led_drive_en_o |->
    integrating_o && k_q == MEAS_PROX && lm_q) else $error("led on wrongly");
  AST_LED_NORMAL: assert property (accp && m_q[2] |=>
    led_drive_en_o && integrating_o) else $error("led not on");
  AST_RANGE: assert property (accp && m_q[5] |=> adc_high_range_o)
    else $error("range not high");
  AST_IR_SEL: assert property (acc && meas_kind_i == MEAS_AMB_IR |=>
    adc_input_sel_o == $past(ir_q)) else $error("ir select wrong");
  AST_AUX_SEL: assert property (acc && meas_kind_i == MEAS_AUX |=>
    adc_input_sel_o == $past(aux_q)) else $error("aux select wrong");
  AST_VIS_WAIT: assert property (acc && meas_kind_i == MEAS_VIS |=>
    recovering_o && !integrating_o) else $error("no recovery");

  COV_PROX: cover property (accp && g_q[2:0] == 3'h7);
  COV_RAW: cover property (accp && !m_q[2]);
  COV_VIS: cover property (acc && meas_kind_i == MEAS_VIS);
endmodule

bind lamc_top lamc_props u_lamc_props (
  .core_clk_i       (core_clk_i),
  .srst_i           (srst_i),
  .reg_addr_i       (reg_addr_i),
  .reg_wdata_i      (reg_wdata_i),
  .reg_wr_i         (reg_wr_i),
  .meas_start_i     (meas_start_i),
  .meas_kind_i      (meas_kind_i),
  .meas_busy_o      (meas_busy_o),
  .meas_done_o      (meas_done_o),
  .recovering_o     (recovering_o),
  .integrating_o    (integrating_o),
  .adc_clk_en_o     (adc_clk_en_o),
  .adc_input_sel_o  (adc_input_sel_o),
  .adc_high_range_o (adc_high_range_o),
  .led_drive_en_o   (led_drive_en_o)
);

// file: verification/lamc_top_tb_top.sv
// Purpose: register and measurement tests for lamc_top
// Assumes: integration shortened to 2 ADC clocks
// Notes:   cycle counts run from the start edge to done
`timescale 1ns/100ps
module lamc_top_tb_top
  import lamc_pkg::*;
;
  localparam logic [7:0] OFS[5] = '{8'h0b, 8'h0c, 8'h0e, 8'h0f, 8'h10};
  localparam logic [7:0] RST[5] = '{8'h00, 8'h04, 8'h00, 8'h65, 8'h70};
  localparam logic [7:0] MSK[5] = '{8'h07, 8'h24, 8'hff, 8'hff, 8'h70};
  localparam logic [7:0] MUX[4] = '{8'h03, 8'h00, 8'h75, 8'h65};
  logic       core_clk_i, srst_i, reg_wr_i, reg_rd_i, meas_start_i;
  logic       vis_high_range_i, early_rev_i, meas_busy_o, meas_done_o;
  logic       recovering_o, integrating_o, adc_clk_en_o;
  logic       adc_high_range_o, led_drive_en_o;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, adc_input_sel_o;
  logic [7:0] prox_input_sel_i, vis_input_sel_i;
  logic [2:0] visible_gain_exponent_i;
  lamc_meas_t meas_kind_i;
  int         errors = 0;
  int         samples_checked = 0;

  lamc_top #(.INTEG_ADC_CLKS(2)) u_lamc_top (.*);

  always #5 core_clk_i = ~core_clk_i;

  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    samples_checked++;
    if (g !== e)
    begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wrt(logic [7:0] a, logic [7:0] d);
    @(posedge core_clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rdc(logic [7:0] a, logic [7:0] e);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    chk("rdata", {8'h00, e}, {8'h00, reg_rdata_o});
  endtask

  task automatic meas(lamc_meas_t k, int c, logic [7:0] s, logic r, logic l);
    int   n;
    logic ls;
    @(posedge core_clk_i);
    meas_kind_i  <= k;
    meas_start_i <= 1'b1;
    @(posedge core_clk_i);
    meas_start_i <= 1'b0;
    #1;
    n  = 1;
    ls = led_drive_en_o;
    chk("sel", {8'h00, s}, {8'h00, adc_input_sel_o});
    chk("range", {15'h0, r}, {15'h0, adc_high_range_o});
    while (meas_done_o !== 1'b1 && n < 6000)
    begin
      @(posedge core_clk_i);
      #1;
      n++;
      ls = ls | led_drive_en_o;
    end
    chk("cycles", 16'(c), 16'(n));
    chk("led", {15'h0, l}, {15'h0, ls});
  endtask

  task automatic test_done;
    $display("compares %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    core_clk_i = 1'b0;
    srst_i = 1'b1;
    {reg_wr_i, reg_rd_i, meas_start_i, vis_high_range_i, early_rev_i} = '0;
    {reg_addr_i, reg_wdata_i, prox_input_sel_i, vis_input_sel_i} = '0;
    visible_gain_exponent_i = 3'h0;
    meas_kind_i = MEAS_PROX;
    repeat (2) @(posedge core_clk_i);
    srst_i <= 1'b0;
    for (int i = 0; i < 5; i++)
      rdc(OFS[i], RST[i]);
    rdc(8'h0d, 8'h00);
    $display("test reset values done");
    for (int i = 0; i < 5; i++)
    begin
      wrt(OFS[i], 8'hff);
      rdc(OFS[i], MSK[i]);
    end
    wrt(8'h0d, 8'hff);
    rdc(8'h0d, 8'h00);
    $display("test register access done");
    prox_input_sel_i <= 8'h03;
    // gains above 5 on purpose: nothing may clamp them
    for (int g = 0; g < 8; g++)
    begin
      wrt(8'h0b, 8'(g));
      wrt(8'h0c, g[0] ? 8'h20 : 8'h04);
      meas(MEAS_PROX, 10 * (1 << g) + 1, 8'h03, g[0], !g[0]);
    end
    wrt(8'h0b, 8'h05);
    rdc(8'h0b, 8'h05);
    $display("test prox gain done");
    for (int i = 0; i < 4; i++)
    begin
      wrt(i < 2 ? 8'h0e : 8'h0f, MUX[i]);
      meas(i < 2 ? MEAS_AMB_IR : MEAS_AUX, 11, MUX[i], 1'b0, 1'b0);
    end
    $display("test input select done");
    vis_input_sel_i <= 8'h5a;
    for (int c = 0; c < 8; c++)
    begin
      visible_gain_exponent_i <= 3'(~c);
      vis_high_range_i <= c[0];
      wrt(8'h10, {1'b0, 3'(c), 4'h0});
      meas(MEAS_VIS, 5 * (1 << (7 - c)) * (c == 0 ? 3 : (4 << c) + 1) + 1,
           8'h5a, c[0], 1'b0);
    end
    $display("test visible recovery done");
    early_rev_i <= 1'b1;
    visible_gain_exponent_i <= 3'h1;
    wrt(8'h10, 8'h20);
    repeat (4) @(posedge core_clk_i);
    meas(MEAS_AMB_IR, 171, 8'h00, 1'b0, 1'b0);
    $display("test early silicon done");
    test_done;
  end

  // all tests need about 23000 cycles
  initial
  begin
    repeat (40000) @(posedge core_clk_i);
    errors++;
    $display("Error watchdog expected finish seen hang");
    test_done;
  end
endmodule
